// *** inc/qpd_pkg.sv ***
// constants, register map and carrier types of the quadrature position decoder
package qpd_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_UPPER_LIMIT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_POSITION = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PHASE_ERR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_VEL_PERIOD = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_VEL_RUNNING = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_VEL_SAVED = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_INT_RAW = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_INT_MASKED = 8'h28;

  // ==========================================================
  // control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_COUNT_BOTH = 1;
  localparam int CTRL_CLEAR_ON_INDEX = 2;
  localparam int CTRL_STEP_DIR = 3;
  localparam int CTRL_SWAP = 4;
  localparam int CTRL_VEL_ENABLE = 5;
  localparam int CTRL_PREDIV_LSB = 6;
  localparam int PREDIV_W = 3;
  localparam int CTRL_W = 9;

  // ==========================================================
  // interrupt bit positions
  localparam int INT_W = 4;
  localparam int INT_PHASE_ERROR = 0;
  localparam int INT_DIRECTION = 1;
  localparam int INT_VEL_PERIOD = 2;
  localparam int INT_INDEX = 3;

  // ==========================================================
  // reset values and direction codes
  localparam logic [DATA_W-1:0] RST_UPPER_LIMIT = 32'hffffffff;
  localparam logic [DATA_W-1:0] RST_VEL_PERIOD = 32'h00000001;
  localparam logic [DATA_W-1:0] DIR_FORWARD = 32'h00000001;
  localparam logic [DATA_W-1:0] DIR_REVERSE = 32'hffffffff;
  localparam int DIV_CNT_W = 7;

  // ==========================================================
  // carriers between bus slave and decoder
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [3:0] strb;
  } qpd_wr_s;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
  } qpd_rd_s;

  typedef struct packed {
    logic a;
    logic b;
    logic index;
  } qpd_pins_s;

  // ==========================================================
  // state records
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic berr;
    logic rvalid;
    logic rerr;
    logic [DATA_W-1:0] rdata;
  } qpd_axi_s;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] upper_limit;
    logic [DATA_W-1:0] position;
    logic [DATA_W-1:0] period;
    logic [DATA_W-1:0] timer;
    logic [DATA_W-1:0] vel_acc;
    logic [DATA_W-1:0] vel_saved;
    logic [DIV_CNT_W-1:0] div_cnt;
    logic dir_fwd;
    logic phase_err;
    logic [INT_W-1:0] int_mask;
    logic [INT_W-1:0] int_raw;
    qpd_pins_s prev;
  } qpd_core_s;

endpackage : qpd_pkg

// *** rtl/qpd_axil_slave.sv ***
// axi4-lite slave front end that turns bus transfers into register strobes
`timescale 1ns/100ps
module qpd_axil_slave (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic [qpd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [qpd_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [qpd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [qpd_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output qpd_pkg::qpd_wr_s reg_wr,
  output qpd_pkg::qpd_rd_s reg_rd,
  input wire logic [qpd_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_err,
  input wire logic wr_err
);

  qpd_pkg::qpd_axi_s st_reg;
  qpd_pkg::qpd_axi_s st_next;

  // ==========================================================
  // handshakes
  // nothing is taken while frozen, so no item is lost under clk_en low
  assign s_axi_awready = clk_en & ~st_reg.aw_held;
  assign s_axi_wready = clk_en & ~st_reg.w_held;
  assign s_axi_arready = clk_en & ~st_reg.rvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.berr ? qpd_pkg::RESP_SLVERR : qpd_pkg::RESP_OKAY;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rerr ? qpd_pkg::RESP_SLVERR : qpd_pkg::RESP_OKAY;

  // write fires once both halves are held and the last answer is gone
  assign reg_wr.en = clk_en & st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
  assign reg_wr.addr = st_reg.aw_addr;
  assign reg_wr.data = st_reg.wdata;
  assign reg_wr.strb = st_reg.wstrb;
  assign reg_rd.en = s_axi_arvalid & s_axi_arready;
  assign reg_rd.addr = s_axi_araddr;

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (reg_wr.en) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.berr = wr_err;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (reg_rd.en) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rd_data;
      st_next.rerr = rd_err;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

endmodule : qpd_axil_slave

// *** rtl/qpd_decoder.sv ***
// quadrature position decoder: edge decode, position, velocity, interrupts
// ==========================================================
// Summary of operation
// - Edges of the first channel only, or of both, feed position and velocity.
// - With clear-on-index the index event resets position; otherwise it leaves it.
// - Inputs are either two phase signals or a step clock plus direction level.
// - With swap set the two channel inputs are exchanged before decoding.
// - An upper limit bounds the position; a reverse index loads that limit.
// - Direction holds the last seen motion and reads as 1 forward, -1 reverse.
// - Both phase inputs changing at once sets a readable phase error.
// - Four sticky interrupt sources each cleared by a bitmask write.
// - A per-source mask decides which sources reach the interrupt output.
// - Interrupt status reads raw, and raw ANDed with the mask.
// - Velocity accumulates only while the decoder itself is enabled.
// - Edges are predivided by 1 to 128, summed over a period, saved, cleared.
// - Position is readable and writable; counting continues from a write.
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module qpd_decoder (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // encoder pins
  input wire logic encoder_input_first,
  input wire logic encoder_input_second,
  input wire logic encoder_index,
  // axi4-lite write
  input wire logic [qpd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [qpd_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [qpd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [qpd_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // status
  output logic irq,
  output logic direction_forward,
  output logic phase_error
);

  qpd_pkg::qpd_core_s st_reg;
  qpd_pkg::qpd_core_s st_next;
  qpd_pkg::qpd_wr_s reg_wr;
  qpd_pkg::qpd_rd_s reg_rd;
  qpd_pkg::qpd_pins_s pins;
  logic [qpd_pkg::DATA_W-1:0] rd_data;
  logic rd_err;
  logic wr_err;

  // ==========================================================
  // bus front end
  qpd_axil_slave u_bus (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .rd_data(rd_data),
    .rd_err(rd_err),
    .wr_err(wr_err)
  );

  // ==========================================================
  // control fields
  logic enable;
  logic count_both_channels;
  logic clear_position_on_index;
  logic step_direction_input_mode;
  logic inputs_exchanged;
  logic vel_enable;
  logic [qpd_pkg::PREDIV_W-1:0] velocity_predivide_setting;

  assign enable = st_reg.ctrl[qpd_pkg::CTRL_ENABLE];
  assign count_both_channels = st_reg.ctrl[qpd_pkg::CTRL_COUNT_BOTH];
  assign clear_position_on_index = st_reg.ctrl[qpd_pkg::CTRL_CLEAR_ON_INDEX];
  assign step_direction_input_mode = st_reg.ctrl[qpd_pkg::CTRL_STEP_DIR];
  assign inputs_exchanged = st_reg.ctrl[qpd_pkg::CTRL_SWAP];
  assign vel_enable = st_reg.ctrl[qpd_pkg::CTRL_VEL_ENABLE];
  assign velocity_predivide_setting =
    st_reg.ctrl[qpd_pkg::CTRL_PREDIV_LSB +: qpd_pkg::PREDIV_W];

  // ==========================================================
  // input decode
  // optional swap
  assign pins.a = inputs_exchanged ? encoder_input_second : encoder_input_first;
  assign pins.b = inputs_exchanged ? encoder_input_first : encoder_input_second;
  assign pins.index = encoder_index;

  logic a_chg;
  logic b_chg;
  logic step_edge;
  logic move_fwd;
  logic count_edge;

  logic phase_error_event;
  logic index_seen_event;
  logic direction_change_event;
  logic velocity_period_event;

  logic div_tick;
  logic [qpd_pkg::DIV_CNT_W-1:0] div_last;

  assign a_chg = pins.a ^ st_reg.prev.a;
  assign b_chg = pins.b ^ st_reg.prev.b;
  // step mode: rising first input
  assign step_edge = pins.a & ~st_reg.prev.a;

  always_comb begin
    if (step_direction_input_mode) begin
      count_edge = enable & step_edge;
      move_fwd = pins.b;
    end else begin
      count_edge = enable & (a_chg ^ b_chg) & (a_chg | count_both_channels);
      move_fwd = pins.a ^ st_reg.prev.b;
    end
  end

  assign phase_error_event = enable & ~step_direction_input_mode & a_chg & b_chg;
  // index acts on its rising edge
  assign index_seen_event = enable & pins.index & ~st_reg.prev.index;

  assign direction_change_event = count_edge & (move_fwd != st_reg.dir_fwd);

  assign div_last = qpd_pkg::DIV_CNT_W'((1 << velocity_predivide_setting) - 1);
  assign div_tick = count_edge & (st_reg.div_cnt == div_last);

  // timer runs only with the decoder enabled
  assign velocity_period_event = enable & vel_enable &
    (st_reg.timer >= st_reg.period - 32'h00000001);

  // ==========================================================
  // register map
  // unstrobed lanes keep old bytes
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : merge

  logic [qpd_pkg::INT_W-1:0] int_masked;
  assign int_masked = st_reg.int_raw & st_reg.int_mask;

  // unmapped: zero data, error
  always_comb begin
    rd_err = 1'b0;
    rd_data = '0;
    unique case (reg_rd.addr)
      qpd_pkg::OFS_CTRL: rd_data = 32'(st_reg.ctrl);
      qpd_pkg::OFS_UPPER_LIMIT: rd_data = st_reg.upper_limit;
      qpd_pkg::OFS_POSITION: rd_data = st_reg.position;
      qpd_pkg::OFS_DIRECTION: rd_data = st_reg.dir_fwd ? qpd_pkg::DIR_FORWARD
                                                       : qpd_pkg::DIR_REVERSE;
      qpd_pkg::OFS_PHASE_ERR: rd_data = 32'(st_reg.phase_err);
      qpd_pkg::OFS_VEL_PERIOD: rd_data = st_reg.period;
      qpd_pkg::OFS_VEL_RUNNING: rd_data = st_reg.vel_acc;
      qpd_pkg::OFS_VEL_SAVED: rd_data = st_reg.vel_saved;
      qpd_pkg::OFS_INT_MASK: rd_data = 32'(st_reg.int_mask);
      qpd_pkg::OFS_INT_RAW: rd_data = 32'(st_reg.int_raw);
      qpd_pkg::OFS_INT_MASKED: rd_data = 32'(int_masked);
      default: rd_err = 1'b1;
    endcase
  end

  always_comb begin
    unique case (reg_wr.addr)
      qpd_pkg::OFS_CTRL, qpd_pkg::OFS_UPPER_LIMIT, qpd_pkg::OFS_POSITION,
      qpd_pkg::OFS_PHASE_ERR, qpd_pkg::OFS_VEL_PERIOD, qpd_pkg::OFS_INT_MASK,
      qpd_pkg::OFS_INT_RAW: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  // ==========================================================
  // next state
  logic [qpd_pkg::INT_W-1:0] int_set;
  logic [qpd_pkg::INT_W-1:0] int_clr;
  logic [31:0] merged;

  always_comb begin
    st_next = st_reg;
    merged = merge(32'h00000000, reg_wr.data, reg_wr.strb);
    int_clr = '0;
    // samples track even while disabled so enabling makes no false edge
    st_next.prev = pins;

    // position counting, wrap at the upper limit
    if (count_edge) begin
      st_next.dir_fwd = move_fwd;
      if (move_fwd) begin
        st_next.position = (st_reg.position >= st_reg.upper_limit) ? '0
                         : st_reg.position + 32'h00000001;
      end else begin
        st_next.position = (st_reg.position == '0) ? st_reg.upper_limit
                         : st_reg.position - 32'h00000001;
      end
    end

    // index reset only in clear mode
    if (index_seen_event && clear_position_on_index) begin
      st_next.position = st_next.dir_fwd ? '0 : st_reg.upper_limit;
    end

    // phase error is sticky until written
    if (phase_error_event) begin
      st_next.phase_err = 1'b1;
    end

    // accumulate predivided edges over the period
    if (enable && vel_enable) begin
      if (count_edge) begin
        st_next.div_cnt = div_tick ? '0 : st_reg.div_cnt + 7'h01;
      end

      if (velocity_period_event) begin
        st_next.vel_saved = st_reg.vel_acc + 32'(div_tick);
        st_next.vel_acc = '0;
        st_next.timer = '0;
      end else begin
        st_next.vel_acc = st_reg.vel_acc + 32'(div_tick);
        st_next.timer = st_reg.timer + 32'h00000001;
      end
    end else begin
      st_next.timer = '0;
      // no stale edges in a new period
      st_next.vel_acc = '0;
      st_next.div_cnt = '0;
    end

    // software writes; a position write wins over counting in that cycle
    if (reg_wr.en) begin
      unique case (reg_wr.addr)
        qpd_pkg::OFS_CTRL: begin
          // enable bit starts and stops decoding
          st_next.ctrl = qpd_pkg::CTRL_W'(merge(32'(st_reg.ctrl), reg_wr.data, reg_wr.strb));
        end
        qpd_pkg::OFS_UPPER_LIMIT: begin
          st_next.upper_limit = merge(st_reg.upper_limit, reg_wr.data, reg_wr.strb);
        end
        qpd_pkg::OFS_POSITION: begin
          // counting resumes from the written value
          st_next.position = merge(st_reg.position, reg_wr.data, reg_wr.strb);
        end
        qpd_pkg::OFS_PHASE_ERR: begin
          if (merged[0] && !phase_error_event) begin
            st_next.phase_err = 1'b0;
          end
        end
        qpd_pkg::OFS_VEL_PERIOD: begin
          // zero would never expire; it is held at one instead
          st_next.period = merge(st_reg.period, reg_wr.data, reg_wr.strb);
          if (st_next.period == '0) begin
            st_next.period = qpd_pkg::RST_VEL_PERIOD;
          end
        end
        qpd_pkg::OFS_INT_MASK: begin
          st_next.int_mask = merged[qpd_pkg::INT_W-1:0];
        end
        qpd_pkg::OFS_INT_RAW: begin
          int_clr = merged[qpd_pkg::INT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // a read of the raw status also clears it
    if (reg_rd.en && reg_rd.addr == qpd_pkg::OFS_INT_RAW) begin
      int_clr = '1;
    end

    // sticky sources, new events win over a clear
    int_set = '0;
    int_set[qpd_pkg::INT_PHASE_ERROR] = phase_error_event;
    int_set[qpd_pkg::INT_DIRECTION] = direction_change_event;
    int_set[qpd_pkg::INT_VEL_PERIOD] = velocity_period_event;
    int_set[qpd_pkg::INT_INDEX] = index_seen_event;
    st_next.int_raw = (st_reg.int_raw & ~int_clr) | int_set;
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.upper_limit <= qpd_pkg::RST_UPPER_LIMIT;
      st_reg.period <= qpd_pkg::RST_VEL_PERIOD;
      // forward until motion is seen
      st_reg.dir_fwd <= 1'b1;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // only enabled sources reach the output
  assign irq = |int_masked;

  assign direction_forward = st_reg.dir_fwd;
  assign phase_error = st_reg.phase_err;

endmodule : qpd_decoder

// *** tb/qpd_enc_model.sv ***
// behavioural incremental encoder driving the decoder pins
`timescale 1ns/100ps
module qpd_enc_model (
  // clock
  input wire logic ref_clk,
  // encoder pins
  output logic encoder_input_first,
  output logic encoder_input_second,
  output logic encoder_index
);
  logic a = 1'h0;
  logic b = 1'h0;
  logic x = 1'h0;
  assign encoder_input_first = a;
  assign encoder_input_second = b;
  assign encoder_index = x;
  // ====
  // motion tasks
  // quadrature gray steps
  task automatic mv(input bit fwd, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if ((a == b) == fwd) a <= ~a;
      else b <= ~b;
      repeat (2) @(posedge ref_clk);
    end
  endtask : mv
  task automatic glitch;
    @(posedge ref_clk);
    a <= ~a;
    b <= ~b;
    repeat (2) @(posedge ref_clk);
  endtask : glitch
  task automatic sd(input bit dir);
    @(posedge ref_clk);
    a <= 1'h0;
    repeat (2) @(posedge ref_clk);
    b <= dir;
    repeat (2) @(posedge ref_clk);
    a <= 1'h1;
    repeat (2) @(posedge ref_clk);
  endtask : sd
  task automatic idx;
    @(posedge ref_clk);
    x <= 1'h1;
    repeat (2) @(posedge ref_clk);
    x <= 1'h0;
    repeat (2) @(posedge ref_clk);
  endtask : idx
endmodule : qpd_enc_model

// *** tb/qpd_chk.sv ***
// port-level assertions of the decoder
`timescale 1ns/100ps
module qpd_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // pins
  input wire logic encoder_input_first,
  input wire logic encoder_input_second,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [qpd_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // status
  input wire logic irq,
  input wire logic direction_forward,
  input wire logic phase_error
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ====
  // steps
  sequence wr_taken;
    clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence pin_moved;
    $past(encoder_input_first) != $past(encoder_input_first, 2) ||
      $past(encoder_input_second) != $past(encoder_input_second, 2);
  endsequence
  wr_answer_a: assert property (wr_taken |-> !s_axi_bvalid ##2 s_axi_bvalid)
    else $error("write answer not two cycles after transfer");
  rd_answer_a: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  err_cause_a: assert property ($rose(phase_error) |-> $past(encoder_input_first) !=
    $past(encoder_input_first, 2) && $past(encoder_input_second) != $past(encoder_input_second, 2))
    else $error("phase error without double change");
  err_keep_a: assert property ($fell(phase_error) |-> s_axi_bvalid)
    else $error("phase error cleared without write");
  dir_cause_a: assert property ($changed(direction_forward) |-> pin_moved)
    else $error("direction changed without pin motion");
  irq_clear_a: assert property ($fell(irq) |-> s_axi_bvalid || s_axi_rvalid)
    else $error("interrupt dropped without bus access");
endmodule : qpd_chk
bind qpd_decoder qpd_chk u_chk (.ref_clk, .rst_n, .clk_en, .encoder_input_first,
  .encoder_input_second, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .irq, .direction_forward, .phase_error);

// *** tb/testbench.sv ***
// self-checking testbench of the quadrature position decoder
`timescale 1ns/100ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end
module testbench;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic clk_en = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq, direction_forward, phase_error;
  logic encoder_input_first, encoder_input_second, encoder_index;
  logic [1:0] s_axi_bresp, s_axi_rresp, be;
  logic [31:0] s_axi_rdata, p;
  logic [33:0] re;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int err_count = 0;
  int total_checks = 0;
  always #5 ref_clk = ~ref_clk;
  qpd_decoder u_dut (.ref_clk, .rst_n, .clk_en, .encoder_input_first, .encoder_input_second,
    .encoder_index, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq, .direction_forward, .phase_error);
  qpd_enc_model u_enc (.ref_clk, .encoder_input_first, .encoder_input_second, .encoder_index);
  // ====
  // bus master
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    bq.push_back(ad > qpd_pkg::OFS_INT_MASKED ? qpd_pkg::RESP_SLVERR : qpd_pkg::RESP_OKAY);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      s_axi_bready <= s_axi_bvalid && !s_axi_bready;
    end while (!(s_axi_bvalid && s_axi_bready));
  endtask : wr
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    @(posedge ref_clk);
    rq.push_back({ad > qpd_pkg::OFS_INT_MASKED ? qpd_pkg::RESP_SLVERR : qpd_pkg::RESP_OKAY, e});
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      s_axi_rready <= s_axi_rvalid && !s_axi_rready;
    end while (!(s_axi_rvalid && s_axi_rready));
  endtask : rd
  // oldest expectation meets each answer
  always @(posedge ref_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      re = rq.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, re)
    end
    if (s_axi_bvalid && s_axi_bready) begin
      be = bq.pop_front();
      `CHK(s_axi_bresp, be)
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // run is far shorter than this
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    finish_test();
  end
  // ====
  // scenarios
  initial begin
    p = $urandom(85);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(qpd_pkg::OFS_CTRL, 32'h0);
    rd(qpd_pkg::OFS_UPPER_LIMIT, qpd_pkg::RST_UPPER_LIMIT);
    rd(qpd_pkg::OFS_DIRECTION, qpd_pkg::DIR_FORWARD);
    rd(qpd_pkg::OFS_INT_RAW, 32'h0);
    rd(8'h3c, 32'h0);
    wr(8'h3c, 32'h5);
    p = $urandom_range(6, 2);
    wr(qpd_pkg::OFS_UPPER_LIMIT, 32'h9);
    wr(qpd_pkg::OFS_POSITION, p);
    wr(qpd_pkg::OFS_INT_MASK, 32'hf);
    wr(qpd_pkg::OFS_CTRL, 32'h3);
    u_enc.mv(1, 3);
    rd(qpd_pkg::OFS_POSITION, p + 32'h3);
    u_enc.mv(0, 1);
    rd(qpd_pkg::OFS_POSITION, p + 32'h2);
    rd(qpd_pkg::OFS_DIRECTION, qpd_pkg::DIR_REVERSE);
    `CHK(direction_forward, 1'h0)
    `CHK(irq, 1'h1)
    rd(qpd_pkg::OFS_INT_RAW, 32'h2);
    `CHK(irq, 1'h0)
    wr(qpd_pkg::OFS_POSITION, 32'h9);
    u_enc.mv(1, 1);
    rd(qpd_pkg::OFS_POSITION, 32'h0);
    u_enc.mv(0, 1);
    rd(qpd_pkg::OFS_POSITION, 32'h9);
    wr(qpd_pkg::OFS_CTRL, 32'h0);
    u_enc.mv(1, 2);
    rd(qpd_pkg::OFS_POSITION, 32'h9);
    wr(qpd_pkg::OFS_CTRL, 32'h1);
    u_enc.mv(1, 4);
    rd(qpd_pkg::OFS_POSITION, 32'h1);
    wr(qpd_pkg::OFS_CTRL, 32'h13);
    u_enc.mv(1, 2);
    rd(qpd_pkg::OFS_POSITION, 32'h9);
    wr(qpd_pkg::OFS_CTRL, 32'h9);
    wr(qpd_pkg::OFS_POSITION, 32'h4);
    u_enc.sd(1);
    u_enc.sd(1);
    u_enc.sd(0);
    rd(qpd_pkg::OFS_POSITION, 32'h5);
    wr(qpd_pkg::OFS_CTRL, 32'h7);
    wr(qpd_pkg::OFS_INT_RAW, 32'hf);
    u_enc.mv(1, 1);
    u_enc.idx();
    rd(qpd_pkg::OFS_POSITION, 32'h0);
    u_enc.mv(0, 2);
    u_enc.idx();
    rd(qpd_pkg::OFS_POSITION, 32'h9);
    wr(qpd_pkg::OFS_CTRL, 32'h3);
    u_enc.mv(0, 1);
    u_enc.idx();
    rd(qpd_pkg::OFS_POSITION, 32'h8);
    rd(qpd_pkg::OFS_INT_RAW, 32'ha);
    wr(qpd_pkg::OFS_INT_MASK, 32'h1);
    u_enc.glitch();
    `CHK(phase_error, 1'h1)
    `CHK(irq, 1'h1)
    rd(qpd_pkg::OFS_PHASE_ERR, 32'h1);
    rd(qpd_pkg::OFS_POSITION, 32'h8);
    u_enc.mv(1, 1);
    rd(qpd_pkg::OFS_INT_MASKED, 32'h1);
    rd(qpd_pkg::OFS_INT_RAW, 32'h3);
    u_enc.mv(0, 1);
    `CHK(irq, 1'h0)
    rd(qpd_pkg::OFS_INT_MASKED, 32'h0);
    wr(qpd_pkg::OFS_PHASE_ERR, 32'h1);
    `CHK(phase_error, 1'h0)
    wr(qpd_pkg::OFS_VEL_PERIOD, 32'h3e8);
    wr(qpd_pkg::OFS_CTRL, 32'h22);
    u_enc.mv(1, 2);
    rd(qpd_pkg::OFS_VEL_RUNNING, 32'h0);
    for (int n = 0; n < 4; n++) begin
      wr(qpd_pkg::OFS_CTRL, 32'h0);
      wr(qpd_pkg::OFS_CTRL, 32'h23 | (32'(n) << 6));
      u_enc.mv(1, 8);
      rd(qpd_pkg::OFS_VEL_RUNNING, 32'h8 >> n);
    end
    // saved total must be read before the second period ends
    wr(qpd_pkg::OFS_CTRL, 32'h0);
    wr(qpd_pkg::OFS_INT_RAW, 32'hf);
    wr(qpd_pkg::OFS_INT_MASK, 32'h4);
    wr(qpd_pkg::OFS_VEL_PERIOD, 32'h10);
    wr(qpd_pkg::OFS_CTRL, 32'h23);
    u_enc.mv(1, 4);
    repeat (8) @(posedge ref_clk);
    `CHK(irq, 1'h1)
    rd(qpd_pkg::OFS_VEL_SAVED, 32'h4);
    rst_n <= 1'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(qpd_pkg::OFS_POSITION, 32'h0);
    finish_test();
  end
endmodule : testbench
